// [common/pds_pkg.sv]
// constants for the power-down, sync and reference control registers
package pds_pkg;

  // serial frame layout: read flag, 7-bit address, 8-bit data, msb first
  localparam int        FRAME_BITS    = 16;
  localparam logic [3:0] HEAD_LAST_BIT = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
  localparam int        ADDR_W        = 7;
  localparam int        DATA_W        = 8;

  // register offsets
  localparam logic [6:0] POWER_DOWN_CONTROL_OFS         = 7'h08;
  localparam logic [6:0] OUTPUT_DRIVER_POWER_DOWN_OFS   = 7'h09;
  localparam logic [6:0] GLOBAL_POWER_DOWN_MASK_OFS     = 7'h0D;
  localparam logic [6:0] SYNC_AND_REFERENCE_CONTROL_OFS = 7'h0E;
  localparam logic [6:0] INPUT_AND_SAMPLING_OPTIONS_OFS = 7'h11;

  // reset values
  localparam logic [7:0] POWER_DOWN_CONTROL_RST         = 8'h02;
  localparam logic [7:0] OUTPUT_DRIVER_POWER_DOWN_RST   = 8'h0C;
  localparam logic [7:0] GLOBAL_POWER_DOWN_MASK_RST     = 8'h00;
  localparam logic [7:0] SYNC_AND_REFERENCE_CONTROL_RST = 8'h00;
  localparam logic [7:0] INPUT_AND_SAMPLING_OPTIONS_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE            = 8'h00;

  // power_down_control fields
  localparam int PDC_GLOBAL_SLEEP_BIT  = 0;
  localparam int PDC_CHAN_A_OFF_BIT    = 2;
  localparam int PDC_REFERENCE_AMP_BIT = 4;
  localparam int PDC_CLOCK_BUFFER_BIT  = 5;

  // output_driver_power_down fields
  localparam int FRAME_CLOCK_DRIVER_OFF_BIT  = 5;
  localparam int BIT_CLOCK_DRIVER_OFF_BIT    = 4;
  localparam int CHAN_A_LANE1_DRIVER_OFF_BIT = 3;
  localparam int CHAN_A_LANE0_DRIVER_OFF_BIT = 2;
  localparam int CHAN_B_LANE1_DRIVER_OFF_BIT = 1;
  localparam int CHAN_B_LANE0_DRIVER_OFF_BIT = 0;

  // global_power_down_mask fields
  localparam int KEEP_CLOCK_BUFFER_ON_BIT  = 3;
  localparam int KEEP_REFERENCE_AMP_ON_BIT = 2;
  localparam int BANDGAP_OFF_IN_SLEEP_BIT  = 1;

  // sync_and_reference_control fields
  localparam int PIN_ROLE_SYNC_BIT               = 7;
  localparam int REGISTER_SYNC_BIT               = 6;
  localparam int REGISTER_SYNC_ENABLE_BIT        = 5;
  localparam int REFERENCE_CHOICE_BY_REGISTER_BIT = 3;
  localparam int REFERENCE_SELECT_HI             = 2;
  localparam int REFERENCE_SELECT_LO             = 1;
  localparam int SINGLE_ENDED_CLOCK_SELECT_BIT   = 0;

  // input_and_sampling_options fields
  localparam int SINGLE_ENDED_INPUT_A_BIT = 5;
  localparam int DELAY_LOOP_OFF_BIT       = 2;
  localparam int AUTO_ZERO_CONTROL_BIT    = 0;

  // reference choices
  localparam logic [1:0] REF_INTERNAL     = 2'h0;
  localparam logic [1:0] REF_EXTERNAL_BUF = 2'h1;
  localparam logic [1:0] REF_EXTERNAL     = 2'h2;

  // serial receiver states
  typedef enum logic [2:0] {
    PDS_IDLE = 3'b001,
    PDS_HEAD = 3'b010,
    PDS_DATA = 3'b100
  } pds_state_t;

endpackage : pds_pkg

// [rtl/pds_regs.sv]
// power-down, sync and reference control register bank behind the serial port
// Functional notes
// - bit 5 of the driver power-down register turns the frame clock output driver off when set.
// - bit 4 of the driver power-down register turns the bit clock output driver off when set.
// - bit 3 turns channel A lane 1 off, resets to 1, and one-lane or half-lane mode forces it off.
// - bit 2 turns channel A lane 0 off when set and resets to 1.
// - bit 1 turns channel B lane 1 off, and one-lane or half-lane mode forces it off.
// - bit 0 turns channel B lane 0 off, and half-lane mode forces it off.
// - mask bit 3 keeps the sampling clock buffer running during global sleep.
// - mask bit 2 keeps the reference amplifier running during global sleep.
// - mask bit 1 switches the bandgap off during global sleep, otherwise it stays on.
// - sync register bit 7 makes a high shared pin mean sleep when 0 and sync when 1.
// - sync register bit 5 moves sync triggering from the shared pin to register bit 6.
// - bit 3 hands reference choice to bits 2-1 and clock type to bit 0, else the reference pin decides.
// - bits 2-1 pick internal, external buffered or external direct reference when bit 3 is set.
// - bit 0 with bit 3 set selects the single-ended clock and turns the differential buffer off.
// - global sleep is requested by bit 0 of the power-down control register and shaped by the mask.
module pds_regs (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // serial programming pins
  input  wire logic       serial_clk_in,
  input  wire logic       serial_enable_n_in,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  // device pins
  input  wire logic       sync_or_sleep_pin_in,
  input  wire logic       reference_buffer_pin_in,
  // output interface mode from the serializer
  input  wire logic       one_lane_mode_in,
  input  wire logic       half_lane_mode_in,
  // output driver controls
  output logic            frame_clock_driver_off_out,
  output logic            bit_clock_driver_off_out,
  output logic            chan_a_lane1_driver_off_out,
  output logic            chan_a_lane0_driver_off_out,
  output logic            chan_b_lane1_driver_off_out,
  output logic            chan_b_lane0_driver_off_out,
  // analog power controls
  output logic            global_sleep_out,
  output logic            clock_buffer_off_out,
  output logic            diff_clock_buffer_off_out,
  output logic            reference_amp_off_out,
  output logic            bandgap_off_out,
  output logic            chan_a_off_out,
  // sync and reference
  output logic            sync_command_out,
  output logic [1:0]      reference_select_out,
  output logic            single_ended_clock_select_out,
  // input options
  output logic            single_ended_input_a_out,
  output logic            delay_loop_off_out,
  output logic            auto_zero_control_out
);

  // synchronised pins
  logic sclk_s, en_n_s, sdi_s, pin_s, reference_buffer_pin_s;
  logic sclk_prev_q;
  logic rise, fall;

  // serial receiver
  pds_pkg::pds_state_t state_q;
  logic [3:0]  bit_cnt_q;
  logic [14:0] shift_in_q;
  logic [7:0]  shift_out_q;
  logic        read_q;
  logic [6:0]  addr_q;
  logic        head_done, frame_done, wr_en;
  logic [7:0]  wr_data, rd_data;

  // registers
  logic [7:0] pd_ctl_q, drv_q, mask_q, syncref_q, opts_q;

  // derived controls
  logic sleep, pin_sync, sync_cmd, se_clk, ref_by_reg, clkbuf_off;
  logic [1:0] ref_sel;

  // all pins cross through two flops
  pds_sync #(
    .WIDTH(5)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({serial_clk_in, serial_enable_n_in, serial_data_in,
                   sync_or_sleep_pin_in, reference_buffer_pin_in}),
    .sync_out    ({sclk_s, en_n_s, sdi_s, pin_s, reference_buffer_pin_s})
  );

  // serial clock edge detection on synchronised level
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign rise       = sclk_s & ~sclk_prev_q;
  assign fall       = ~sclk_s & sclk_prev_q;
  assign head_done  = rise && (state_q == pds_pkg::PDS_HEAD) && (bit_cnt_q == pds_pkg::HEAD_LAST_BIT);
  assign frame_done = rise && (state_q == pds_pkg::PDS_DATA) && (bit_cnt_q == pds_pkg::FRAME_LAST_BIT);
  assign wr_data    = {shift_in_q[6:0], sdi_s};
  assign wr_en      = frame_done && !read_q;

  // frame sequencing, enable low frames the transfer
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q    <= pds_pkg::PDS_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_in_q <= 15'h0000;
      read_q     <= 1'b0;
      addr_q     <= 7'h00;
    end else if (en_n_s) begin
      state_q   <= pds_pkg::PDS_IDLE;
      bit_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        pds_pkg::PDS_IDLE: begin
          state_q   <= pds_pkg::PDS_HEAD;
          bit_cnt_q <= 4'h0;
        end
        pds_pkg::PDS_HEAD: begin
          if (rise) begin
            shift_in_q <= {shift_in_q[13:0], sdi_s};
            bit_cnt_q  <= bit_cnt_q + 4'h1;
          end
          if (head_done) begin
            state_q <= pds_pkg::PDS_DATA;
            read_q  <= shift_in_q[6];
            addr_q  <= {shift_in_q[5:0], sdi_s};
          end
        end
        pds_pkg::PDS_DATA: begin
          if (rise) begin
            shift_in_q <= {shift_in_q[13:0], sdi_s};
            bit_cnt_q  <= bit_cnt_q + 4'h1;
          end
          if (frame_done) begin
            state_q <= pds_pkg::PDS_HEAD; // back-to-back frames allowed
          end
        end
      endcase
    end
  end

  // read-back data loaded at end of header, shifted on falling edges
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      shift_out_q <= 8'h00;
    end else if (head_done) begin
      shift_out_q <= rd_data;
    end else if (fall && (state_q == pds_pkg::PDS_DATA)) begin
      shift_out_q <= {shift_out_q[6:0], 1'b0};
    end
  end

  assign serial_data_out = shift_out_q[7];

  // read mux keyed by the address in the header being completed
  always_comb begin
    unique case ({shift_in_q[5:0], sdi_s})
      pds_pkg::POWER_DOWN_CONTROL_OFS:         rd_data = pd_ctl_q;
      pds_pkg::OUTPUT_DRIVER_POWER_DOWN_OFS:   rd_data = drv_q;
      pds_pkg::GLOBAL_POWER_DOWN_MASK_OFS:     rd_data = mask_q;
      pds_pkg::SYNC_AND_REFERENCE_CONTROL_OFS: rd_data = syncref_q;
      pds_pkg::INPUT_AND_SAMPLING_OPTIONS_OFS: rd_data = opts_q;
      default:                                 rd_data = pds_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  // power_down_control register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pd_ctl_q <= pds_pkg::POWER_DOWN_CONTROL_RST;
    end else if (wr_en && addr_q == pds_pkg::POWER_DOWN_CONTROL_OFS) begin
      pd_ctl_q <= wr_data;
    end
  end

  // output_driver_power_down register, lanes 0 and 1 of A off at reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      drv_q <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST;
    end else if (wr_en && addr_q == pds_pkg::OUTPUT_DRIVER_POWER_DOWN_OFS) begin
      drv_q <= wr_data;
    end
  end

  // global_power_down_mask register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mask_q <= pds_pkg::GLOBAL_POWER_DOWN_MASK_RST;
    end else if (wr_en && addr_q == pds_pkg::GLOBAL_POWER_DOWN_MASK_OFS) begin
      mask_q <= wr_data;
    end
  end

  // sync_and_reference_control register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      syncref_q <= pds_pkg::SYNC_AND_REFERENCE_CONTROL_RST;
    end else if (wr_en && addr_q == pds_pkg::SYNC_AND_REFERENCE_CONTROL_OFS) begin
      syncref_q <= wr_data;
    end
  end

  // input_and_sampling_options register, bits 5, 2 and 0 feed the option outputs
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      opts_q <= pds_pkg::INPUT_AND_SAMPLING_OPTIONS_RST;
    end else if (wr_en && addr_q == pds_pkg::INPUT_AND_SAMPLING_OPTIONS_OFS) begin
      opts_q <= wr_data;
    end
  end

  // sleep and sync sources
  assign sleep      = pd_ctl_q[pds_pkg::PDC_GLOBAL_SLEEP_BIT] |
                      (~syncref_q[pds_pkg::PIN_ROLE_SYNC_BIT] & pin_s);
  assign pin_sync   = syncref_q[pds_pkg::PIN_ROLE_SYNC_BIT] & pin_s;
  assign sync_cmd   = syncref_q[pds_pkg::REGISTER_SYNC_ENABLE_BIT] ?
                      syncref_q[pds_pkg::REGISTER_SYNC_BIT] : pin_sync;
  assign ref_by_reg = syncref_q[pds_pkg::REFERENCE_CHOICE_BY_REGISTER_BIT];
  assign ref_sel    = ref_by_reg ? syncref_q[pds_pkg::REFERENCE_SELECT_HI:pds_pkg::REFERENCE_SELECT_LO] :
                      (reference_buffer_pin_s ? pds_pkg::REF_EXTERNAL_BUF : pds_pkg::REF_INTERNAL);
  assign se_clk     = ref_by_reg & syncref_q[pds_pkg::SINGLE_ENDED_CLOCK_SELECT_BIT];
  assign clkbuf_off = pd_ctl_q[pds_pkg::PDC_CLOCK_BUFFER_BIT] |
                      (sleep & ~mask_q[pds_pkg::KEEP_CLOCK_BUFFER_ON_BIT]);

  // registered driver controls
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      frame_clock_driver_off_out  <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::FRAME_CLOCK_DRIVER_OFF_BIT];
      bit_clock_driver_off_out    <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::BIT_CLOCK_DRIVER_OFF_BIT];
      chan_a_lane1_driver_off_out <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::CHAN_A_LANE1_DRIVER_OFF_BIT];
      chan_a_lane0_driver_off_out <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::CHAN_A_LANE0_DRIVER_OFF_BIT];
      chan_b_lane1_driver_off_out <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::CHAN_B_LANE1_DRIVER_OFF_BIT];
      chan_b_lane0_driver_off_out <= pds_pkg::OUTPUT_DRIVER_POWER_DOWN_RST[pds_pkg::CHAN_B_LANE0_DRIVER_OFF_BIT];
    end else begin
      frame_clock_driver_off_out  <= drv_q[pds_pkg::FRAME_CLOCK_DRIVER_OFF_BIT];
      bit_clock_driver_off_out    <= drv_q[pds_pkg::BIT_CLOCK_DRIVER_OFF_BIT];
      chan_a_lane1_driver_off_out <= drv_q[pds_pkg::CHAN_A_LANE1_DRIVER_OFF_BIT] |
                                     one_lane_mode_in | half_lane_mode_in;
      chan_a_lane0_driver_off_out <= drv_q[pds_pkg::CHAN_A_LANE0_DRIVER_OFF_BIT];
      chan_b_lane1_driver_off_out <= drv_q[pds_pkg::CHAN_B_LANE1_DRIVER_OFF_BIT] |
                                     one_lane_mode_in | half_lane_mode_in;
      chan_b_lane0_driver_off_out <= drv_q[pds_pkg::CHAN_B_LANE0_DRIVER_OFF_BIT] |
                                     half_lane_mode_in;
    end
  end

  // registered analog, sync and reference controls
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      global_sleep_out              <= 1'b0;
      clock_buffer_off_out          <= 1'b0;
      diff_clock_buffer_off_out     <= 1'b0;
      reference_amp_off_out         <= 1'b0;
      bandgap_off_out               <= 1'b0;
      chan_a_off_out                <= 1'b0;
      sync_command_out              <= 1'b0;
      reference_select_out          <= pds_pkg::REF_INTERNAL;
      single_ended_clock_select_out <= 1'b0;
      single_ended_input_a_out      <= 1'b0;
      delay_loop_off_out            <= 1'b0;
      auto_zero_control_out         <= 1'b0;
    end else begin
      global_sleep_out              <= sleep;
      clock_buffer_off_out          <= clkbuf_off;
      diff_clock_buffer_off_out     <= clkbuf_off | se_clk;
      reference_amp_off_out         <= pd_ctl_q[pds_pkg::PDC_REFERENCE_AMP_BIT] |
                                       (sleep & ~mask_q[pds_pkg::KEEP_REFERENCE_AMP_ON_BIT]);
      bandgap_off_out               <= sleep & mask_q[pds_pkg::BANDGAP_OFF_IN_SLEEP_BIT];
      chan_a_off_out                <= pd_ctl_q[pds_pkg::PDC_CHAN_A_OFF_BIT] | sleep;
      sync_command_out              <= sync_cmd;
      reference_select_out          <= ref_sel;
      single_ended_clock_select_out <= se_clk;
      single_ended_input_a_out      <= opts_q[pds_pkg::SINGLE_ENDED_INPUT_A_BIT];
      delay_loop_off_out            <= opts_q[pds_pkg::DELAY_LOOP_OFF_BIT];
      auto_zero_control_out         <= opts_q[pds_pkg::AUTO_ZERO_CONTROL_BIT];
    end
  end

  // assertion arming: one cycle after reset release
  logic armed_q;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in || !armed_q);

  sequence s_frame_write_drv;
    wr_en && addr_q == pds_pkg::OUTPUT_DRIVER_POWER_DOWN_OFS;
  endsequence

  a_frame_clock_out_off_follow: assert property (frame_clock_driver_off_out ==
    $past(drv_q[pds_pkg::FRAME_CLOCK_DRIVER_OFF_BIT])) else $error("frame clock driver control wrong");
  a_bit_clock_out_off_write: assert property (s_frame_write_drv ##1 1'b1 |=>
    bit_clock_driver_off_out == $past(drv_q[pds_pkg::BIT_CLOCK_DRIVER_OFF_BIT])) else $error("bit clock driver wrong");
  a_lane_a1_forced: assert property ((one_lane_mode_in || half_lane_mode_in) |=>
    chan_a_lane1_driver_off_out) else $error("lane a1 not forced off");
  a_lane_a0_follow: assert property (chan_a_lane0_driver_off_out ==
    $past(drv_q[pds_pkg::CHAN_A_LANE0_DRIVER_OFF_BIT])) else $error("lane a0 control wrong");
  a_lane_b1_forced: assert property ((one_lane_mode_in || half_lane_mode_in) |=>
    chan_b_lane1_driver_off_out) else $error("lane b1 not forced off");
  a_lane_b0_state: assert property ((!half_lane_mode_in && !drv_q[pds_pkg::CHAN_B_LANE0_DRIVER_OFF_BIT]) |=>
    !chan_b_lane0_driver_off_out) else $error("lane b0 off without cause");
  a_clkbuf_masked: assert property ((sleep && mask_q[pds_pkg::KEEP_CLOCK_BUFFER_ON_BIT] &&
    !pd_ctl_q[pds_pkg::PDC_CLOCK_BUFFER_BIT]) |=> !clock_buffer_off_out) else $error("clock buffer not kept on");
  a_refamp_sleep: assert property ((sleep && !mask_q[pds_pkg::KEEP_REFERENCE_AMP_ON_BIT]) |=>
    reference_amp_off_out) else $error("reference amp not off in sleep");
  a_bandgap_sleep: assert property (bandgap_off_out ==
    ($past(sleep) && $past(mask_q[pds_pkg::BANDGAP_OFF_IN_SLEEP_BIT]))) else $error("bandgap control wrong");
  a_pin_role_sleep: assert property ((pin_s && !syncref_q[pds_pkg::PIN_ROLE_SYNC_BIT]) |=>
    global_sleep_out) else $error("pin did not enter sleep");
  a_reg_sync_only: assert property (syncref_q[pds_pkg::REGISTER_SYNC_ENABLE_BIT] |=>
    sync_command_out == $past(syncref_q[pds_pkg::REGISTER_SYNC_BIT])) else $error("register sync wrong");
  a_ref_by_pin: assert property (!ref_by_reg |=> (reference_select_out == ($past(reference_buffer_pin_s) ?
    pds_pkg::REF_EXTERNAL_BUF : pds_pkg::REF_INTERNAL))) else $error("pin reference choice wrong");
  a_ref_by_reg: assert property (ref_by_reg |=> reference_select_out ==
    $past(syncref_q[pds_pkg::REFERENCE_SELECT_HI:pds_pkg::REFERENCE_SELECT_LO])) else $error("register reference wrong");
  a_se_clock_diff: assert property (single_ended_clock_select_out |-> diff_clock_buffer_off_out)
    else $error("differential buffer on with single-ended clock");
  a_global_bit: assert property (pd_ctl_q[pds_pkg::PDC_GLOBAL_SLEEP_BIT] |=> global_sleep_out)
    else $error("register sleep not applied");

endmodule : pds_regs

// [rtl/pds_sync.sv]
// two flip-flop synchroniser for asynchronous pin levels
module pds_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pds_sync

// [test/tb_power_down_sync_ref_control_regs.sv]
// self-checking bench for the power-down, sync and reference register bank
module tb_power_down_sync_ref_control_regs;
  timeunit 1ns;
  timeprecision 100ps;

  // design pins
  logic       core_clk_in, reset_in, serial_clk_in, serial_enable_n_in, serial_data_in, serial_data_out;
  logic       sync_or_sleep_pin_in, reference_buffer_pin_in, one_lane_mode_in, half_lane_mode_in;
  logic       frame_clock_driver_off_out, bit_clock_driver_off_out, chan_a_lane1_driver_off_out;
  logic       chan_a_lane0_driver_off_out, chan_b_lane1_driver_off_out, chan_b_lane0_driver_off_out;
  logic       global_sleep_out, clock_buffer_off_out, diff_clock_buffer_off_out, reference_amp_off_out;
  logic       bandgap_off_out, chan_a_off_out, sync_command_out, single_ended_clock_select_out;
  logic [1:0] reference_select_out;
  logic       single_ended_input_a_out, delay_loop_off_out, auto_zero_control_out;
  // bench state
  int         failures, checked;
  logic [31:0] seed;
  logic [7:0] v, q, m, pd;

  pds_regs u_dut (.core_clk_in, .reset_in, .serial_clk_in, .serial_enable_n_in, .serial_data_in,
    .serial_data_out, .sync_or_sleep_pin_in, .reference_buffer_pin_in, .one_lane_mode_in,
    .half_lane_mode_in, .frame_clock_driver_off_out, .bit_clock_driver_off_out,
    .chan_a_lane1_driver_off_out, .chan_a_lane0_driver_off_out, .chan_b_lane1_driver_off_out,
    .chan_b_lane0_driver_off_out, .global_sleep_out, .clock_buffer_off_out, .diff_clock_buffer_off_out,
    .reference_amp_off_out, .bandgap_off_out, .chan_a_off_out, .sync_command_out, .reference_select_out,
    .single_ended_clock_select_out, .single_ended_input_a_out, .delay_loop_off_out, .auto_zero_control_out);

  // 125 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected driver offs: frame, bit, a1, a0, b1, b0
  function automatic logic [5:0] exp_drv(input logic [7:0] r, input logic one, input logic half);
    return {r[5], r[4], r[3] | one | half, r[2], r[1] | one | half, r[0] | half};
  endfunction : exp_drv

  // expected sleep, clock buffer, ref amp, bandgap and channel a offs
  function automatic logic [4:0] exp_pwr(input logic [7:0] p, input logic [7:0] k, input logic pin_sleep);
    logic s;
    s = p[0] | pin_sleep;
    return {s, p[5] | (s & ~k[3]), p[4] | (s & ~k[2]), s & k[1], p[2] | s};
  endfunction : exp_pwr

  // expected sync, single-ended clock, diff buffer off, reference choice; mask clear, so pin sleep stops the buffer
  function automatic logic [4:0] exp_sr(input logic [7:0] r, input logic pin, input logic refpin);
    return {r[5] ? r[6] : (r[7] & pin), r[3] & r[0], (r[3] & r[0]) | (pin & ~r[7]),
      r[3] ? r[2:1] : {1'b0, refpin}};
  endfunction : exp_sr

  // compare seen against expected
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // step n clocks, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  // one 16-bit serial frame, msb first, read data taken at the end of high phases 8 to 15
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] w;
    w = {rd, a, d};
    r = 8'h00;
    serial_enable_n_in = 1'b0;
    tick(5);
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = w[i];
      tick(5);
      serial_clk_in = 1'b1;
      tick(5);
      if (i > 0 && i < 9) r = {r[6:0], serial_data_out};
      serial_clk_in = 1'b0;
    end
    tick(5);
    serial_enable_n_in = 1'b1;
    tick(8);
  endtask : frame

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    frame(1'b0, a, d, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    frame(1'b1, a, 8'h00, r);
    check("readback", r, exp);
  endtask : rd

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // watchdog
  initial begin
    repeat (80000) @(posedge core_clk_in);
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    failures = 0; checked = 0; seed = 32'd48808;
    reset_in = 1'b1; serial_clk_in = 1'b0; serial_enable_n_in = 1'b1; serial_data_in = 1'b0;
    sync_or_sleep_pin_in = 1'b0; reference_buffer_pin_in = 1'b0; one_lane_mode_in = 1'b0; half_lane_mode_in = 1'b0;
    tick(4);
    reset_in = 1'b0;
    tick(4);
    // reset values at the pins and in the table
    check("drv_rst", {2'b00, frame_clock_driver_off_out, bit_clock_driver_off_out, chan_a_lane1_driver_off_out,
      chan_a_lane0_driver_off_out, chan_b_lane1_driver_off_out, chan_b_lane0_driver_off_out}, 8'h0C);
    rd(7'h08, 8'h02); rd(7'h09, 8'h0C); rd(7'h0D, 8'h00); rd(7'h0E, 8'h00); rd(7'h11, 8'h00); rd(7'h20, 8'h00);
    $display("test reset done");
    // driver power-down bits against lane modes
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : 8'(rnd()) & 8'h3F;
      one_lane_mode_in = (i == 2) ? 1'b1 : (i > 2) ? 1'(rnd()) : 1'b0;
      half_lane_mode_in = (i == 1) ? 1'b1 : (i > 2) ? 1'(rnd()) : 1'b0;
      wr(7'h09, v);
      check("drv", {2'b00, frame_clock_driver_off_out, bit_clock_driver_off_out, chan_a_lane1_driver_off_out,
        chan_a_lane0_driver_off_out, chan_b_lane1_driver_off_out, chan_b_lane0_driver_off_out},
        {2'b00, exp_drv(v, one_lane_mode_in, half_lane_mode_in)});
      rd(7'h09, v);
    end
    $display("test drivers done");
    // global sleep masks, from the register bit and from the pin
    for (int i = 0; i < 16; i++) begin
      m = {4'h0, i[2:0], 1'b0};
      q = 8'(rnd());
      pd = {2'b00, q[5:4], 1'b0, q[2], 1'b1, ~i[3]};
      wr(7'h0D, m);
      wr(7'h0E, 8'h00);
      wr(7'h08, pd);
      sync_or_sleep_pin_in = i[3];
      tick(6);
      check("pwr", {3'b000, global_sleep_out, clock_buffer_off_out, reference_amp_off_out, bandgap_off_out,
        chan_a_off_out}, {3'b000, exp_pwr(pd, m, i[3])});
      sync_or_sleep_pin_in = 1'b0;
      wr(7'h08, 8'h02);
      check("wake", {3'b000, global_sleep_out, clock_buffer_off_out, reference_amp_off_out, bandgap_off_out,
        chan_a_off_out}, {3'b000, exp_pwr(8'h02, m, 1'b0)});
    end
    rd(7'h0D, m);
    $display("test sleep done");
    // pin role, register sync and reference choice
    wr(7'h0D, 8'h00);
    for (int i = 0; i < 14; i++) begin
      q = 8'(rnd());
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h60 : (i == 2) ? 8'hA0 : (i == 3) ? 8'h0D : (i == 4) ? 8'h0B :
        (i == 5) ? 8'h05 : q & 8'hEF;
      if (v[2:1] == 2'b11) v[2] = 1'b0;
      sync_or_sleep_pin_in = (i < 6) ? 1'b1 : 1'(rnd());
      reference_buffer_pin_in = (i == 5) ? 1'b1 : 1'(rnd());
      wr(7'h0E, v);
      tick(6);
      check("sync_ref", {3'b000, sync_command_out, single_ended_clock_select_out, diff_clock_buffer_off_out,
        reference_select_out}, {3'b000, exp_sr(v, sync_or_sleep_pin_in, reference_buffer_pin_in)});
      check("pin_sleep", {7'h00, global_sleep_out}, {7'h00, sync_or_sleep_pin_in & ~v[7]});
      rd(7'h0E, v);
    end
    sync_or_sleep_pin_in = 1'b0;
    $display("test sync_ref done");
    // input option bits
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h25 : (i == 1) ? 8'h00 : 8'(rnd()) & 8'h25;
      wr(7'h11, v);
      check("inopt", {5'h00, single_ended_input_a_out, delay_loop_off_out, auto_zero_control_out},
        {5'h00, v[5], v[2], v[0]});
      rd(7'h11, v);
    end
    $display("test options done");
    // second reset mid-run restores the defaults
    reset_in = 1'b1;
    tick(4);
    reset_in = 1'b0;
    tick(4);
    rd(7'h09, 8'h0C);
    rd(7'h11, 8'h00);
    $display("test rereset done");
    finish_test();
  end

endmodule : tb_power_down_sync_ref_control_regs
